/* common/pll_switch_pkg.sv */
package pll_switch_pkg;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;

    // Control register fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_MODE_W = 2;
    localparam logic [1:0] CTRL_MODE_RST = 2'h0;

    // Status register fields
    localparam int STAT_LOST_PRI_BIT = 0;
    localparam int STAT_LOST_BAK_BIT = 1;
    localparam int STAT_ACTIVE_BIT = 2;
    localparam int STAT_BUSY_BIT = 3;

    // Selection values
    localparam logic SEL_PRIMARY = 1'b0;

    // Timing counts, in reference input cycles
    localparam logic [1:0] LOST_LIMIT = 2'h2;
    localparam logic [1:0] MAN_HOLD_CYCLES = 2'h3;

    typedef enum logic [1:0] {
        MODE_AUTO = 2'h0,
        MODE_MANUAL = 2'h1,
        MODE_OVERRIDE = 2'h2
    } sw_mode_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_DRAIN = 2'h1,
        ST_HOLD = 2'h3
    } sw_state_t;

endpackage : pll_switch_pkg

/* logic/ref_edge_sense.sv */
`timescale 1ns/1ps
module ref_edge_sense (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic pin_in,
    output logic level,
    output logic rise,
    output logic fall
);
    // Stage 0 only feeds stage 1; stage 2 is the edge history
    logic [2:0] sh_r;

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            sh_r <= 3'h0;
        end else begin
            sh_r <= {sh_r[1:0], pin_in};
        end
    end

    assign level = sh_r[1];
    assign rise = sh_r[1] & ~sh_r[2];
    assign fall = ~sh_r[1] & sh_r[2];

endmodule : ref_edge_sense

/* logic/pll_ref_switch.sv */
`timescale 1ns/1ps
// Behaviour
// - Auto mode: when selected input stops toggling, switch to the other input.
// - Manual mode: swap inputs after request rises and stays high three cycles.
// - Override mode: high switch request beats the automatic stopped-clock decision.
// - Primary input is selected after reset.
// - Outputs: lost flag per input plus a selected-input indicator.
// - Auto mode: lost flag rises when its input is found stopped.
// - Lost flags unreliable if frequencies differ over 20%; indicator stays valid.
// - Indicator shows which input drives the loop reference.
// - No switchover when both inputs are stopped.
// - Stuck-low input flagged after about two cycles, then the other input selected.
// - Gate reference on old input's fall; switch mux and indicator on new's fall.
// - Override with both running: a held request rise swaps the indicator, no lost flag.
// - Only rising request edges act; a falling edge never switches back.
// - Switch to a stopped input waits until that input toggles.
// - Auto switching back and forth is unlimited.
module pll_ref_switch
    import pll_switch_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic ref_in_primary,
    input wire logic ref_in_backup,
    input wire logic switch_req,
    output logic ref_out,
    output logic lost_primary,
    output logic lost_backup,
    output logic active_backup,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);

    logic [1:0] lvl;
    logic [1:0] rise;
    logic [1:0] fall;
    logic req_lvl;
    logic req_rise;

    ref_edge_sense u_sense_pri (
        .core_clk(core_clk),
        .rstn(rstn),
        .pin_in(ref_in_primary),
        .level(lvl[0]),
        .rise(rise[0]),
        .fall(fall[0])
    );

    ref_edge_sense u_sense_bak (
        .core_clk(core_clk),
        .rstn(rstn),
        .pin_in(ref_in_backup),
        .level(lvl[1]),
        .rise(rise[1]),
        .fall(fall[1])
    );

    ref_edge_sense u_sense_req (
        .core_clk(core_clk),
        .rstn(rstn),
        .pin_in(switch_req),
        .level(req_lvl),
        .rise(req_rise),
        .fall()
    );

    // Register file
    logic [1:0] mode_r;
    logic ack_r;
    logic [31:0] rdat_r;
    wire bus_req = wb_cyc_i & wb_stb_i & ~ack_r;
    wire hit_ctrl = (wb_adr_i[7:2] == CTRL_OFS[7:2]);
    wire hit_stat = (wb_adr_i[7:2] == STATUS_OFS[7:2]);
    wire ctrl_wr = bus_req & wb_we_i & hit_ctrl & wb_sel_i[0];

    // Mode decode; the unused encoding behaves as manual
    wire auto_en = (mode_r == MODE_AUTO) | (mode_r == MODE_OVERRIDE);
    wire man_en = (mode_r != MODE_AUTO);
    wire override_en = (mode_r == MODE_OVERRIDE);

    // Stopped-clock detection
    logic [1:0] idle_cnt_r [2];
    logic [1:0] det_lost;
    assign det_lost[0] = (idle_cnt_r[0] == LOST_LIMIT);
    assign det_lost[1] = (idle_cnt_r[1] == LOST_LIMIT);

    always_ff @(posedge core_clk) begin
        for (int i = 0; i < 2; i++) begin
            if (!rstn) begin
                idle_cnt_r[i] <= 2'h0;
            end else if (rise[i] || fall[i]) begin
                // Either own edge proves activity, so an input half as fast is not flagged
                idle_cnt_r[i] <= 2'h0;
            end else if (rise[1 - i] && !det_lost[i]) begin
                idle_cnt_r[i] <= idle_cnt_r[i] + 2'h1;
            end
        end
    end

    // Switch state machine
    sw_state_t st_r;
    sw_state_t st_nxt;
    logic sel_r;
    logic req_armed_r;
    logic [1:0] hold_cnt_r;

    wire st_idle = (st_r == ST_IDLE);
    wire old_lvl = sel_r ? lvl[1] : lvl[0];
    wire new_fall = sel_r ? fall[0] : fall[1];
    wire sel_lost = sel_r ? det_lost[1] : det_lost[0];
    wire alt_lost = sel_r ? det_lost[0] : det_lost[1];
    wire sel_rise = sel_r ? rise[1] : rise[0];

    wire man_trig = man_en & st_idle & req_armed_r & req_lvl & (hold_cnt_r == MAN_HOLD_CYCLES);
    // In override mode, request held high blocks the automatic decision
    wire auto_block = override_en & req_lvl;
    wire auto_trig = auto_en & st_idle & sel_lost & ~alt_lost & ~auto_block;
    wire trig = man_trig | auto_trig;

    always_comb begin
        st_nxt = st_r;
        case (st_r)
            ST_IDLE: begin
                if (trig) begin
                    st_nxt = ST_DRAIN;
                end
            end
            ST_DRAIN: begin
                // Old input low: gating now cannot clip a high phase
                if (!old_lvl) begin
                    st_nxt = ST_HOLD;
                end
            end
            ST_HOLD: begin
                // A stopped target never falls, so the switch waits
                if (new_fall) begin
                    st_nxt = ST_IDLE;
                end
            end
            default: begin
                st_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            st_r <= ST_IDLE;
            sel_r <= SEL_PRIMARY;
        end else begin
            st_r <= st_nxt;
            if (st_r == ST_HOLD && new_fall) begin
                sel_r <= ~sel_r;
            end
        end
    end

    // Manual request: armed only by a rising edge, disarmed when used or dropped
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            req_armed_r <= 1'b0;
            hold_cnt_r <= 2'h0;
        end else if (req_rise) begin
            req_armed_r <= 1'b1;
            hold_cnt_r <= 2'h0;
        end else if (man_trig || !req_lvl) begin
            req_armed_r <= 1'b0;
            hold_cnt_r <= 2'h0;
        end else if (req_armed_r && sel_rise && hold_cnt_r != MAN_HOLD_CYCLES) begin
            hold_cnt_r <= hold_cnt_r + 2'h1;
        end
    end

    // Registered outputs
    logic ref_out_r;
    logic lost_pri_r;
    logic lost_bak_r;

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            ref_out_r <= 1'b0;
            lost_pri_r <= 1'b0;
            lost_bak_r <= 1'b0;
        end else begin
            ref_out_r <= (st_r != ST_HOLD) & old_lvl;
            lost_pri_r <= auto_en & det_lost[0];
            lost_bak_r <= auto_en & det_lost[1];
        end
    end

    assign ref_out = ref_out_r;
    assign lost_primary = lost_pri_r;
    assign lost_backup = lost_bak_r;
    assign active_backup = sel_r;

    // Wishbone slave: one wait state, unmapped reads return zero
    wire [31:0] stat_word = {28'h0, ~st_idle, sel_r, lost_bak_r, lost_pri_r};
    wire [31:0] ctrl_word = {30'h0, mode_r};
    wire [31:0] rd_mux = hit_ctrl ? ctrl_word : (hit_stat ? stat_word : 32'h0);

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            mode_r <= CTRL_MODE_RST;
            ack_r <= 1'b0;
            rdat_r <= 32'h0;
        end else begin
            ack_r <= bus_req;
            if (bus_req) begin
                rdat_r <= rd_mux;
            end
            if (ctrl_wr) begin
                mode_r <= wb_dat_i[CTRL_MODE_LSB +: CTRL_MODE_W];
            end
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdat_r;

    // Checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    property p_gate_in_hold;
        (st_r == ST_HOLD) |=> !ref_out_r;
    endproperty
    a_gate_in_hold: assert property (p_gate_in_hold) else $error("reference not gated while holding");

    property p_sel_from_hold;
        $changed(sel_r) |-> ($past(st_r) == ST_HOLD) && $past(new_fall);
    endproperty
    a_sel_from_hold: assert property (p_sel_from_hold) else $error("select changed outside new-input fall");

    property p_reset_primary;
        !$past(rstn) |-> (sel_r == SEL_PRIMARY) && st_idle;
    endproperty
    a_reset_primary: assert property (p_reset_primary) else $error("primary not selected after reset");

    property p_auto_start;
        auto_trig |=> (st_r == ST_DRAIN);
    endproperty
    a_auto_start: assert property (p_auto_start) else $error("stopped input did not start switchover");

    property p_both_dead;
        (st_idle && det_lost == 2'h3 && !man_trig) |=> st_idle;
    endproperty
    a_both_dead: assert property (p_both_dead) else $error("switch started with both inputs stopped");

    property p_override;
        (st_idle && override_en && req_lvl && !man_trig) |=> st_idle;
    endproperty
    a_override: assert property (p_override) else $error("auto switch while request held high");

    property p_lost_flag;
        (auto_en && det_lost[0]) |=> lost_pri_r;
    endproperty
    a_lost_flag: assert property (p_lost_flag) else $error("primary lost flag not raised");

    property p_manual_no_flag;
        (mode_r == MODE_MANUAL) |=> !lost_pri_r && !lost_bak_r;
    endproperty
    a_manual_no_flag: assert property (p_manual_no_flag) else $error("lost flag in manual mode");

    property p_one_shot;
        man_trig |=> !req_armed_r && (st_r == ST_DRAIN);
    endproperty
    a_one_shot: assert property (p_one_shot) else $error("request not disarmed after switch");

    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack held longer than one cycle");

    property p_ack_answer;
        bus_req |=> wb_ack_o;
    endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("bus request not acknowledged next cycle");

    property p_hold_waits;
        (st_r == ST_HOLD && !new_fall) |=> (st_r == ST_HOLD) && $stable(sel_r);
    endproperty
    a_hold_waits: assert property (p_hold_waits) else $error("switch completed without a new-input fall");

    property p_drain_gate;
        (st_r == ST_DRAIN && !old_lvl) |=> (st_r == ST_HOLD) && !ref_out_r;
    endproperty
    a_drain_gate: assert property (p_drain_gate) else $error("reference not gated on old-input fall");

    property p_req_low_disarms;
        !req_lvl |=> !req_armed_r;
    endproperty
    a_req_low_disarms: assert property (p_req_low_disarms) else $error("armed after request low");

    property p_lost_clears;
        (auto_en && !det_lost[1]) |=> !lost_bak_r;
    endproperty
    a_lost_clears: assert property (p_lost_clears) else $error("backup lost flag raised wrongly");

endmodule : pll_ref_switch

/* dv/fabric_model.sv */
`timescale 1ns/1ps
module fabric_model (
    input wire logic core_clk,
    input wire logic pri_run,
    input wire logic bak_run,
    input wire logic req_cmd,
    input wire logic lost_primary,
    input wire logic lost_backup,
    input wire logic active_backup,
    output logic ref_in_primary,
    output logic ref_in_backup,
    output logic switch_req,
    output logic phase_detector_enable,
    output logic loop_reset
);
    logic act_seen;
    // Stopped references sit stuck low; periods stay within a factor of two
    initial begin
        ref_in_primary = 1'b0;
        forever #100 ref_in_primary = pri_run ? ~ref_in_primary : 1'b0;
    end
    initial begin
        ref_in_backup = 1'b0;
        forever #117 ref_in_backup = bak_run ? ~ref_in_backup : 1'b0;
    end
    // Request rises only while both run, then is held as long as commanded
    always @(posedge core_clk) begin
        switch_req <= req_cmd & (switch_req | (pri_run & bak_run));
        // Oscillator keeps its frequency while either reference is flagged
        phase_detector_enable <= ~(lost_primary | lost_backup);
        // One core cycle (20 ns) of loop reset after each change of selection
        act_seen <= active_backup;
        loop_reset <= ((act_seen ^ active_backup) === 1'b1);
    end
endmodule : fabric_model

/* dv/tb_top.sv */
`timescale 1ns/1ps
`define CHK(nm, ex, got) n_compared++; if ((got) !== (ex)) begin failures++; \
    $display("wrong value %s expected %h seen %h", nm, ex, got); end
module tb_top;
    import pll_switch_pkg::*;
    logic core_clk, rstn, pri_run, bak_run, req_cmd, cyc, stb, we;
    logic [7:0] adr;
    logic [31:0] dat, rdv;
    wire logic ref_in_primary, ref_in_backup, switch_req, ref_out;
    wire logic lost_primary, lost_backup, active_backup, wb_ack_o;
    wire logic phase_detector_enable, loop_reset;
    logic saw_loop_reset = 1'b0;
    wire logic [31:0] wb_dat_o;
    wire logic [2:0] st = {active_backup, lost_backup, lost_primary};
    int failures = 0;
    int n_compared = 0;

    fabric_model u_fabric_model (.core_clk(core_clk), .pri_run(pri_run), .bak_run(bak_run),
        .req_cmd(req_cmd), .ref_in_primary(ref_in_primary), .ref_in_backup(ref_in_backup),
        .switch_req(switch_req), .lost_primary(lost_primary), .lost_backup(lost_backup),
        .active_backup(active_backup), .phase_detector_enable(phase_detector_enable), .loop_reset(loop_reset));
    pll_ref_switch u_pll_ref_switch (.core_clk(core_clk), .rstn(rstn), .ref_in_primary(ref_in_primary),
        .ref_in_backup(ref_in_backup), .switch_req(switch_req), .ref_out(ref_out),
        .lost_primary(lost_primary), .lost_backup(lost_backup), .active_backup(active_backup),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
        .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

    initial core_clk = 1'b0;
    always #10 core_clk = ~core_clk;

    always @(posedge core_clk) begin
        if (loop_reset === 1'b1) begin
            saw_loop_reset <= 1'b1;
        end
    end

    task automatic conclude;
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : conclude

    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
    endtask : idle

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int i;
        @(posedge core_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        for (i = 0; i < 20; i++) begin
            @(posedge core_clk);
            if (wb_ack_o === 1'b1) break;
        end
        q = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (i == 20) begin
            failures++;
            conclude();
        end
    endtask : wb

    task automatic wait_st(input int b, input logic v);
        int i;
        for (i = 0; i < 400; i++) begin
            @(posedge core_clk);
            if (st[b] === v) break;
        end
        if (i == 400) begin
            failures++;
            conclude();
        end
    endtask : wait_st

    task automatic check_toggle;
        logic hi, lo;
        hi = 1'b0;
        lo = 1'b0;
        repeat (40) begin
            @(posedge core_clk);
            hi = hi | (ref_out === 1'b1);
            lo = lo | (ref_out === 1'b0);
        end
        `CHK("ref_out toggles", 1'b1, hi & lo)
    endtask : check_toggle

    initial begin
        {rstn, pri_run, bak_run, req_cmd, cyc, stb, we, adr, dat} = '0;
        pri_run = 1'b1;
        bak_run = 1'b1;
        idle(2);
        rstn <= 1'b1;
        @(posedge core_clk);
        `CHK("active_backup", 1'b0, active_backup)
        `CHK("lost flags", 2'h0, {lost_backup, lost_primary})
        wb(1'b0, CTRL_OFS, 32'h0, rdv);
        `CHK("mode", 2'h0, rdv[1:0])
        wb(1'b0, 8'h40, 32'h0, rdv);
        `CHK("unmapped", 32'h0, rdv)
        $display("test reset done");
        idle(40);
        pri_run <= 1'b0;
        wait_st(0, 1'b1);
        `CHK("lost_primary", 1'b1, lost_primary)
        wait_st(2, 1'b1);
        `CHK("active_backup", 1'b1, active_backup)
        check_toggle();
        `CHK("phase_detector_enable", 1'b0, phase_detector_enable)
        `CHK("loop_reset seen", 1'b1, saw_loop_reset)
        wb(1'b0, STATUS_OFS, 32'h0, rdv);
        `CHK("status", 3'h5, rdv[2:0])
        pri_run <= 1'b1;
        wait_st(0, 1'b0);
        `CHK("lost_primary", 1'b0, lost_primary)
        bak_run <= 1'b0;
        wait_st(2, 1'b0);
        `CHK("active_backup", 1'b0, active_backup)
        `CHK("lost_backup", 1'b1, lost_backup)
        pri_run <= 1'b0;
        idle(100);
        `CHK("active_backup", 1'b0, active_backup)
        pri_run <= 1'b1;
        bak_run <= 1'b1;
        idle(60);
        `CHK("phase_detector_enable", 1'b1, phase_detector_enable)
        $display("test auto done");
        wb(1'b1, CTRL_OFS, 32'(MODE_MANUAL), rdv);
        idle(40);
        `CHK("active_backup", 1'b0, active_backup)
        req_cmd <= 1'b1;
        idle(2);
        req_cmd <= 1'b0;
        idle(80);
        `CHK("short request", 1'b0, active_backup)
        req_cmd <= 1'b1;
        wait_st(2, 1'b1);
        `CHK("active_backup", 1'b1, active_backup)
        req_cmd <= 1'b0;
        idle(80);
        `CHK("after fall", 1'b1, active_backup)
        req_cmd <= 1'b1;
        wait_st(2, 1'b0);
        idle(100);
        `CHK("held request", 1'b0, active_backup)
        req_cmd <= 1'b0;
        idle(20);
        $display("test manual done");
        wb(1'b1, CTRL_OFS, 32'(MODE_OVERRIDE), rdv);
        idle(20);
        req_cmd <= 1'b1;
        wait_st(2, 1'b1);
        `CHK("active_backup", 1'b1, active_backup)
        `CHK("lost flags", 2'h0, {lost_backup, lost_primary})
        bak_run <= 1'b0;
        idle(100);
        `CHK("override hold", 1'b1, active_backup)
        $display("test override done");
        conclude();
    end
endmodule : tb_top
